/* src/alrb_bridge.v */
// Bus-to-register bridge: AXI4-Lite slave front end, register decode,
// identify data RAM and custom command RAM.
// Assumes the bus runs on processor_clock, which mclk samples as a pin,
// and that the storage core and pattern testers run on mclk.
// Contract
// - Identify RAM holds 8 Kbyte, written 256 bits wide, read 32 bits wide.
// - Identify byte enables 3:0 are write strobe AND dword enable bit 0.
// - Dword enable bits 1 to 7 drive byte enable groups 7:4 to 31:28.
// - Custom command RAM is true dual-port 8 Kbyte with dword-derived enables.
// - Write address, write data, read address, read data are independent.
// - Bus requests cross into the logic domain; read data crosses back.
// - One shared register address serves writes or reads, never both.
// - A register write is one strobe cycle with address, data, lanes.
// - Byte lane bit n marks write data byte n valid.
// - Read request holds its address unchanged until read acknowledge.
// - Register side returns data with an acknowledge; it goes to the bus.
// - Four user areas of 0x200 bytes from 0x0000 to 0x07ff.
// - 0x2000 to 0x3fff reads the identify RAM, read-only.
// - 0x4000 to 0x5fff writes and reads the custom command RAM.
// - 0x6000 to 0x7fff maps to the custom command interface.
// - 0x8000 to 0xffff maps to shared parameters, link status, version.
// - Upper address bits pick the submodule, lower bits the item.
// - Registers are whole 32-bit words; byte lanes are not applied.
// - Read data returns three cycles after request via three flops.
`include "alrb_map.vh"
`timescale 1ns/10ps
`default_nettype none

module alrb_bridge (
	input  wire          mclk,
	input  wire          rst,
	input  wire          processor_clock,
	input  wire [15:0]   s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [15:0]   s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	output reg  [12:0]   sub_word_addr,
	output reg  [5:0]    sub_write_sel,
	output reg  [31:0]   sub_write_value,
	output reg  [3:0]    sub_byte_lanes,
	input  wire [127:0]  user_read_value,
	input  wire [31:0]   cmd_read_value,
	input  wire [31:0]   shared_read_value,
	input  wire          iden_write_strobe,
	input  wire [7:0]    iden_dword_write_enables,
	input  wire [7:0]    iden_line_addr,
	input  wire [255:0]  iden_write_value,
	input  wire          ctm_write_strobe,
	input  wire [7:0]    ctm_dword_write_enables,
	input  wire [7:0]    ctm_line_addr,
	input  wire [255:0]  ctm_write_value,
	output reg  [255:0]  ctm_read_value
);

	// Input sampling: two flops, then one more so that values seen at a
	// detected clock rise are those that stood before the edge.
	wire [`ALRB_SYNC_W-1:0] pin_in;
	reg  [`ALRB_SYNC_W-1:0] sync1;
	reg  [`ALRB_SYNC_W-1:0] sync2;
	reg  [`ALRB_SYNC_W-1:0] sync3;
	assign pin_in = {processor_clock, s_axi_awvalid, s_axi_awaddr,
		s_axi_wvalid, s_axi_wdata, s_axi_wstrb, s_axi_bready,
		s_axi_arvalid, s_axi_araddr, s_axi_rready};

	always @(posedge mclk) begin
		sync1 <= pin_in;
		sync2 <= sync1;
		sync3 <= sync2;
	end

	wire        p_rise  = sync2[73] & ~sync3[73];
	wire        awvalid = sync3[72];
	wire [15:0] awaddr  = sync3[71:56];
	wire        wvalid  = sync3[55];
	wire [31:0] wdata   = sync3[54:23];
	wire [3:0]  wstrb   = sync3[22:19];
	wire        bready  = sync3[18];
	wire        arvalid = sync3[17];
	wire [15:0] araddr  = sync3[16:1];
	wire        rready  = sync3[0];

	// Register interface between front end and decode.
	reg  [`ALRB_WORD_W-1:0] reg_word_address;
	reg                     reg_write_strobe;
	reg  [31:0]             reg_write_value;
	reg  [3:0]              reg_byte_lanes;
	reg                     reg_read_request;
	reg                     reg_read_ack;
	reg  [31:0]             reg_read_value;
	reg  [15:0]             aw_addr;
	reg  [15:0]             ar_addr;
	reg  [31:0]             w_data;
	reg  [3:0]              w_lanes;
	reg                     rd_busy;
	// The master judged valid at its clock rise, which the detector sees
	// two edges late, so handshakes use valid as it stood back then.
	reg  [1:0]              bvalid_hist;
	reg  [1:0]              rvalid_hist;

	wire wr_ready_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire rd_ready_go = ~s_axi_arready & ~s_axi_rvalid & ~rd_busy;

	always @(posedge mclk) begin
		if (rst) begin
			s_axi_awready    <= 1'b1;
			s_axi_wready     <= 1'b1;
			s_axi_arready    <= 1'b1;
			s_axi_bvalid     <= 1'b0;
			s_axi_rvalid     <= 1'b0;
			s_axi_bresp      <= `ALRB_RESP_OKAY;
			s_axi_rresp      <= `ALRB_RESP_OKAY;
			s_axi_rdata      <= 32'h0;
			aw_addr          <= 16'h0;
			ar_addr          <= 16'h0;
			w_data           <= 32'h0;
			w_lanes          <= 4'h0;
			rd_busy          <= 1'b0;
			reg_word_address <= {`ALRB_WORD_W{1'b0}};
			reg_write_strobe <= 1'b0;
			reg_write_value  <= 32'h0;
			reg_byte_lanes   <= 4'h0;
			reg_read_request <= 1'b0;
			bvalid_hist      <= 2'h0;
			rvalid_hist      <= 2'h0;
		end else begin
			reg_write_strobe <= 1'b0;
			reg_read_request <= 1'b0;
			bvalid_hist      <= {bvalid_hist[0], s_axi_bvalid};
			rvalid_hist      <= {rvalid_hist[0], s_axi_rvalid};
			if (p_rise) begin
				if (s_axi_awready && awvalid) begin
					aw_addr       <= awaddr;
					s_axi_awready <= 1'b0;
				end
				if (s_axi_wready && wvalid) begin
					w_data       <= wdata;
					w_lanes      <= wstrb;
					s_axi_wready <= 1'b0;
				end
				if (bvalid_hist[1] && bready) begin
					s_axi_bvalid  <= 1'b0;
					s_axi_awready <= 1'b1;
					s_axi_wready  <= 1'b1;
				end
				if (s_axi_arready && arvalid) begin
					ar_addr       <= araddr;
					s_axi_arready <= 1'b0;
				end
				if (rvalid_hist[1] && rready) begin
					s_axi_rvalid  <= 1'b0;
					s_axi_arready <= 1'b1;
				end
			end
			// Writes win the shared address; a read waits for the next slot.
			if (wr_ready_go && !rd_busy) begin
				reg_word_address <= aw_addr[15:2];
				reg_write_value  <= w_data;
				reg_byte_lanes   <= w_lanes;
				reg_write_strobe <= 1'b1;
				s_axi_bvalid     <= 1'b1;
				s_axi_bresp      <= `ALRB_RESP_OKAY;
			end else if (rd_ready_go && !wr_ready_go) begin
				reg_word_address <= ar_addr[15:2];
				reg_read_request <= 1'b1;
				rd_busy          <= 1'b1;
			end
			if (reg_read_ack) begin
				s_axi_rdata  <= reg_read_value;
				s_axi_rresp  <= `ALRB_RESP_OKAY;
				s_axi_rvalid <= 1'b1;
				rd_busy      <= 1'b0;
			end
		end
	end

	// Address decode: upper bits pick the area, lower bits go out.
	reg [2:0] area;
	reg [1:0] user_idx;
	always @* begin
		user_idx = reg_word_address[8:7];
		if (reg_word_address[13]) begin
			area = `ALRB_AREA_SHARE;
		end else if (reg_word_address[12:11] == 2'h1) begin
			area = `ALRB_AREA_IDEN;
		end else if (reg_word_address[12:11] == 2'h2) begin
			area = `ALRB_AREA_CTM;
		end else if (reg_word_address[12:11] == 2'h3) begin
			area = `ALRB_AREA_CMD;
		end else if (reg_word_address[10:9] == 2'h0) begin
			area = `ALRB_AREA_USER;
		end else begin
			area = `ALRB_AREA_NONE;
		end
	end

	// Write strobes to submodules; whole words, lanes only passed along.
	always @(posedge mclk) begin
		if (rst) begin
			sub_word_addr   <= {`ALRB_SUB_W{1'b0}};
			sub_write_sel   <= 6'h0;
			sub_write_value <= 32'h0;
			sub_byte_lanes  <= 4'h0;
		end else begin
			sub_word_addr   <= reg_word_address[12:0];
			sub_write_value <= reg_write_value;
			sub_byte_lanes  <= reg_byte_lanes;
			sub_write_sel   <= 6'h0;
			if (reg_write_strobe) begin
				if (area == `ALRB_AREA_USER) begin
					sub_write_sel[user_idx] <= 1'b1;
				end else if (area == `ALRB_AREA_CMD) begin
					sub_write_sel[4] <= 1'b1;
				end else if (area == `ALRB_AREA_SHARE) begin
					sub_write_sel[5] <= 1'b1;
				end
			end
		end
	end

	// Dword enables become byte enables; only bit 0 is gated by the strobe.
	wire [31:0] iden_byte_en;
	wire [31:0] ctm_byte_en;
	assign iden_byte_en = {{4{iden_dword_write_enables[7]}},
		{4{iden_dword_write_enables[6]}}, {4{iden_dword_write_enables[5]}},
		{4{iden_dword_write_enables[4]}}, {4{iden_dword_write_enables[3]}},
		{4{iden_dword_write_enables[2]}},
		{4{iden_dword_write_enables[1]}},
		{4{iden_write_strobe & iden_dword_write_enables[0]}}};
	assign ctm_byte_en = {{4{ctm_dword_write_enables[7]}},
		{4{ctm_dword_write_enables[6]}}, {4{ctm_dword_write_enables[5]}},
		{4{ctm_dword_write_enables[4]}}, {4{ctm_dword_write_enables[3]}},
		{4{ctm_dword_write_enables[2]}},
		{4{ctm_dword_write_enables[1]}},
		{4{ctm_write_strobe & ctm_dword_write_enables[0]}}};

	// Both RAMs are kept as 32-bit words; a 256-bit line is eight words.
	reg [31:0] identify_data_ram [0:`ALRB_RAM_WORDS-1];
	reg [31:0] custom_cmd_ram [0:`ALRB_RAM_WORDS-1];
	reg [31:0] iden_q;
	reg [31:0] ctm_q;
	wire [10:0] ram_waddr = reg_word_address[10:0];
	integer i;
	integer j;
	integer k;
	integer m;

	always @(posedge mclk) begin
		for (i = 0; i < `ALRB_RAM_LINE_W; i = i + 1) begin
			for (j = 0; j < 4; j = j + 1) begin
				if (iden_byte_en[4*i+j]) begin
					identify_data_ram[{iden_line_addr, i[2:0]}][8*j +: 8]
						<= iden_write_value[32*i+8*j +: 8];
				end
			end
		end
		iden_q <= identify_data_ram[ram_waddr];
	end

	// On a same-word collision of the two write ports, the register write wins.
	always @(posedge mclk) begin
		for (k = 0; k < `ALRB_RAM_LINE_W; k = k + 1) begin
			for (m = 0; m < 4; m = m + 1) begin
				if (ctm_byte_en[4*k+m]) begin
					custom_cmd_ram[{ctm_line_addr, k[2:0]}][8*m +: 8]
						<= ctm_write_value[32*k+8*m +: 8];
				end
			end
			ctm_read_value[32*k +: 32] <=
				custom_cmd_ram[{ctm_line_addr, k[2:0]}];
		end
		if (reg_write_strobe && area == `ALRB_AREA_CTM) begin
			custom_cmd_ram[ram_waddr] <= reg_write_value;
		end
		ctm_q <= custom_cmd_ram[ram_waddr];
	end

	// Three-stage read pipeline; acknowledge is the request delayed.
	reg [`ALRB_RD_LAT-2:0] rd_pipe;
	reg [2:0]              area1;
	reg [2:0]              area2;
	reg [1:0]              user1;
	reg [31:0]             ext_q;
	always @(posedge mclk) begin
		if (rst) begin
			rd_pipe        <= {(`ALRB_RD_LAT-1){1'b0}};
			reg_read_ack   <= 1'b0;
			reg_read_value <= 32'h0;
			area1          <= 3'h0;
			area2          <= 3'h0;
			user1          <= 2'h0;
			ext_q          <= 32'h0;
		end else begin
			rd_pipe      <= {rd_pipe[`ALRB_RD_LAT-3:0], reg_read_request};
			reg_read_ack <= rd_pipe[`ALRB_RD_LAT-2];
			area1        <= area;
			user1        <= user_idx;
			area2        <= area1;
			if (area1 == `ALRB_AREA_USER) begin
				ext_q <= user_read_value[32*user1 +: 32];
			end else if (area1 == `ALRB_AREA_CMD) begin
				ext_q <= cmd_read_value;
			end else if (area1 == `ALRB_AREA_SHARE) begin
				ext_q <= shared_read_value;
			end else begin
				ext_q <= 32'h0;
			end
			if (area2 == `ALRB_AREA_IDEN) begin
				reg_read_value <= iden_q;
			end else if (area2 == `ALRB_AREA_CTM) begin
				reg_read_value <= ctm_q;
			end else begin
				reg_read_value <= ext_q;
			end
		end
	end

endmodule // alrb_bridge

`default_nettype wire

/* src/alrb_map.vh */
// Constants for the bus-to-register bridge: address map and pipeline figures.
// Assumes byte addresses of 16 bits and 32-bit register words.
`ifndef ALRB_MAP_VH
`define ALRB_MAP_VH

`define ALRB_ADDR_W      16
`define ALRB_WORD_W      14
`define ALRB_SUB_W       13
`define ALRB_SYNC_W      74
`define ALRB_RD_LAT      3
`define ALRB_RAM_WORDS   2048
`define ALRB_RAM_LINE_W  8
`define ALRB_RAM_WADDR_W 11
`define ALRB_USER_BASE   16'h0000
`define ALRB_USER_SPAN   16'h0200
`define ALRB_USER_LAST   16'h07ff
`define ALRB_IDEN_BASE   16'h2000
`define ALRB_CTM_BASE    16'h4000
`define ALRB_CMD_BASE    16'h6000
`define ALRB_SHARE_BASE  16'h8000
`define ALRB_AREA_USER   3'h0
`define ALRB_AREA_IDEN   3'h1
`define ALRB_AREA_CTM    3'h2
`define ALRB_AREA_CMD    3'h3
`define ALRB_AREA_SHARE  3'h4
`define ALRB_AREA_NONE   3'h7
`define ALRB_RESP_OKAY   2'h0

`endif

/* tb/alrb_sva.sv */
// Port checker for the bus-to-register bridge.
// Assumes it is bound onto alrb_bridge and that all checks run on mclk.
`timescale 1ns/10ps
`default_nettype none
module alrb_sva (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [5:0]  sub_write_sel,
	input wire logic [12:0] sub_word_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// A pending write may delay the read, so the upper bound has slack.
	sequence rd_wait;
		!s_axi_rvalid [*5] ##[1:10] s_axi_rvalid;
	endsequence
	sequence wr_done;
		##[1:10] s_axi_bvalid;
	endsequence
	AST_RDLAT: assert property ($fell(s_axi_arready) |-> rd_wait)
		else $error("read data outside latency window");
	AST_BVAL: assert property ($fell(s_axi_wready) |-> wr_done)
		else $error("write response missing");
	AST_BDONE: assert property ($fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
		else $error("write slots not freed");
	AST_BOK: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	AST_ROK: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
		else $error("read response not okay");
	AST_RHOLD: assert property (s_axi_rvalid && $past(s_axi_rvalid) |-> $stable(s_axi_rdata))
		else $error("read data moved while valid");
	AST_PULSE: assert property (sub_write_sel != 6'h0 |=> sub_write_sel == 6'h0)
		else $error("write select longer than one cycle");
	AST_USER: assert property (sub_write_sel[3:0] != 4'h0 |-> sub_word_addr[12:9] == 4'h0 && sub_write_sel[3:0] == 4'h1 << sub_word_addr[8:7])
		else $error("user area select wrong");
	AST_CMD: assert property (sub_write_sel[4] |-> sub_word_addr[12:11] == 2'h3 && sub_write_sel == 6'h10)
		else $error("command area select wrong");
endmodule // alrb_sva
bind alrb_bridge alrb_sva alrb_sva_i (.*);
`default_nettype wire

/* tb/alrb_cpu.sv */
// Processor core model: AXI4-Lite master clocked by processor_clock.
// Assumes the bridge samples that clock with its own mclk.
`timescale 1ns/10ps
`default_nettype none
module alrb_cpu (
	input  wire logic        processor_clock,
	output var  logic [15:0] s_axi_awaddr,
	output var  logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var  logic [31:0] s_axi_wdata,
	output var  logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output var  logic        s_axi_bready,
	output var  logic [15:0] s_axi_araddr,
	output var  logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output var  logic        s_axi_rready
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
		s_axi_wstrb = 4'hf;
	end
	task automatic wr(input logic [15:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ha;
		logic hd;
		@(posedge processor_clock);
		#1;
		{s_axi_awaddr, s_axi_wdata} = {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h7;
		while (s_axi_awvalid || s_axi_wvalid) begin
			@(posedge processor_clock);
			ha = s_axi_awready && s_axi_awvalid;
			hd = s_axi_wready && s_axi_wvalid;
			#1;
			// Released lines flip so a stale value never looks live.
			if (ha) {s_axi_awvalid, s_axi_awaddr} = {1'b0, ~a};
			if (hd) {s_axi_wvalid, s_axi_wdata} = {1'b0, ~d};
		end
		do @(posedge processor_clock); while (!s_axi_bvalid);
		r = s_axi_bresp;
		#1;
		s_axi_bready = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge processor_clock);
		#1;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = {a, 2'h3};
		do @(posedge processor_clock); while (!s_axi_arready);
		#1;
		{s_axi_araddr, s_axi_arvalid} = {~a, 1'b0};
		do @(posedge processor_clock); while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		#1;
		s_axi_rready = 1'b0;
	endtask
endmodule // alrb_cpu
`default_nettype wire

/* tb/test_alrb_bridge.sv */
// Self-checking bench for the bus-to-register bridge.
// Assumes alrb_bridge, the alrb_cpu master model and the alrb_sva checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
	miscompares++; $display("unexpected %s exp %h got %h", n, e, s); end end
module test_alrb_bridge;
	logic mclk = 0, rst = 1, processor_clock = 0;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb, sub_byte_lanes;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, sub_write_value;
	logic [31:0] cmd_read_value, shared_read_value;
	logic [12:0] sub_word_addr;
	logic [5:0] sub_write_sel;
	logic [127:0] user_read_value;
	logic iden_write_strobe = 0, ctm_write_strobe = 0;
	logic [7:0] iden_dword_write_enables = 0, iden_line_addr = 0;
	logic [7:0] ctm_dword_write_enables = 0, ctm_line_addr = 0;
	logic [255:0] iden_write_value = 0, ctm_write_value = 0, ctm_read_value;
	logic [31:0] iden_m [int], ctm_m [int];
	logic [54:0] wq [$];
	logic [15:0] ad [8] = '{16'h0010, 16'h0204, 16'h0408, 16'h07fc,
		16'h1000, 16'h6008, 16'h8004, 16'hfffc};
	integer seed = 51383;
	int miscompares = 0, num_checks = 0;
	function automatic logic [31:0] av(input logic [7:0] k,
		input logic [6:0] w);
		return {k, 17'h0, w};
	endfunction
	function automatic logic [255:0] rv();
		for (int i = 0; i < 8; i++) rv[32*i+:32] = $random(seed);
	endfunction
	function automatic logic [31:0] ex(input logic [15:0] a);
		if (a < 16'h0800) return av(a[10:9], a[8:2]);
		if (a < 16'h2000) return 32'h0;
		if (a < 16'h4000) return iden_m[a[12:2]];
		if (a < 16'h6000) return ctm_m[a[12:2]];
		return av(a[15] ? 8'h88 : 8'h66, a[8:2]);
	endfunction
	assign user_read_value = {av(3, sub_word_addr[6:0]),
		av(2, sub_word_addr[6:0]), av(1, sub_word_addr[6:0]),
		av(0, sub_word_addr[6:0])};
	assign cmd_read_value = av(8'h66, sub_word_addr[6:0]);
	assign shared_read_value = av(8'h88, sub_word_addr[6:0]);
	alrb_bridge alrb_bridge_i (.*);
	alrb_cpu alrb_cpu_i (.*);
	always #20 mclk = ~mclk;
	initial #7 forever #160 processor_clock = ~processor_clock;
	always @(posedge mclk) begin
		if (!rst && |sub_write_sel) wq.push_back({sub_write_sel,
			sub_word_addr, sub_write_value, sub_byte_lanes});
	end
	task automatic bw(input logic [15:0] a, input logic [31:0] d);
		logic [1:0] r;
		logic [5:0] s;
		logic [54:0] q;
		alrb_cpu_i.wr(a, d, r);
		`CHK("bresp", 2'h0, r)
		s = a < 16'h0800 ? 6'h1 << a[10:9] : a[15] ? 6'h20 :
			a[15:13] == 3'h3 ? 6'h10 : 6'h0;
		if (a[15:13] == 3'h2) ctm_m[a[12:2]] = d;
		q = wq.size() ? wq.pop_front() : 55'h0;
		`CHK("sub write", s ? {s, a[14:2], d, 4'hf} : 55'h0, q)
	endtask
	task automatic br(input logic [15:0] a);
		logic [31:0] d;
		logic [1:0] r;
		alrb_cpu_i.rd(a, d, r);
		`CHK("rresp", 2'h0, r)
		`CHK("rdata", ex(a), d)
	endtask
	task automatic ramw(input bit c, input logic [7:0] l, e, input bit s,
		input logic [255:0] v);
		@(negedge mclk);
		if (c) {ctm_write_strobe, ctm_dword_write_enables, ctm_line_addr,
			ctm_write_value} = {s, e, l, v};
		else {iden_write_strobe, iden_dword_write_enables, iden_line_addr,
			iden_write_value} = {s, e, l, v};
		for (int n = 0; n < 8; n++) begin
			if (c && (n ? e[n] : s & e[0])) ctm_m[{l, n[2:0]}] = v[32*n+:32];
			if (!c && (n ? e[n] : s & e[0])) iden_m[{l, n[2:0]}] = v[32*n+:32];
		end
		@(negedge mclk);
		{iden_write_strobe, iden_dword_write_enables} = 9'h0;
		{ctm_write_strobe, ctm_dword_write_enables} = 9'h0;
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		miscompares++;
		results;
	end
	initial begin
		repeat (8) @(negedge mclk);
		`CHK("idle", 5'h1c, {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid})
		rst = 0;
		repeat (8) @(negedge mclk);
		foreach (ad[i]) begin
			bw(ad[i], $random(seed));
			br(ad[i]);
		end
		$display("test areas done");
		ramw(0, 8'h05, 8'hff, 1, rv());
		ramw(0, 8'h05, 8'h0f, 0, rv());
		bw(16'h20a0, $random(seed));
		for (int n = 0; n < 8; n++) br(16'h20a0 + 16'(4 * n));
		$display("test identify done");
		bw(16'h4128, $random(seed));
		br(16'h4128);
		@(negedge mclk);
		ctm_line_addr = 8'h09;
		@(negedge mclk);
		`CHK("ctm line", ctm_m[74], ctm_read_value[95:64])
		ramw(1, 8'h0a, 8'h81, 1, rv());
		br(16'h4140);
		br(16'h415c);
		$display("test custom done");
		fork
			bw(16'h0604, $random(seed));
			br(16'h8008);
		join
		$display("test overlap done");
		results;
	end
endmodule // test_alrb_bridge
`default_nettype wire
